/* File: common/flash_pkg.sv */
// Shared constants and types for the serial flash command engine
package flash_pkg;

    // ==========================================================
    // Opcodes
    localparam logic [7:0] OP_READ_FAST = 8'h0b;
    localparam logic [7:0] OP_READ_SLOW = 8'h03;
    localparam logic [7:0] OP_READ_DUAL = 8'h3b;
    localparam logic [7:0] OP_PROGRAM = 8'h02;
    localparam logic [7:0] OP_PAGE_ERASE = 8'h81;

    // ==========================================================
    // Array geometry and frame layout
    localparam int ARRAY_ADDR_W = 17;
    localparam int PAGE_ADDR_W = 8;
    localparam logic [8:0] PAGE_BYTES = 9'h100;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [2:0] HDR_BYTES = 3'h4;
    localparam logic [2:0] HDR_DUMMY_BYTES = 3'h5;
    localparam logic [2:0] NBYTES_MAX = 3'h5;
    localparam logic [2:0] SINGLE_LAST_BIT = 3'h7;
    localparam logic [2:0] DUAL_LAST_PAIR = 3'h3;

    // ==========================================================
    // Self-timed cycle lengths
    localparam int SYS_CLK_NS = 8;
    // Kept short so three full-page cycles fit one bench run
    localparam int BYTE_PROG_NS = 80;
    localparam int BYTE_ERASE_NS = 80;
    localparam logic [11:0] BYTE_PROG_CYC = 12'((BYTE_PROG_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);
    localparam logic [11:0] BYTE_ERASE_CYC = 12'((BYTE_ERASE_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);

    // ==========================================================
    // Types
    typedef enum logic [2:0] {
        CMD_NONE,
        CMD_READ,
        CMD_FAST,
        CMD_DUAL,
        CMD_PROG,
        CMD_ERASE
    } cmd_t;

    typedef struct packed {
        cmd_t cmd;
        logic [2:0] nbytes;
        logic [2:0] bitpos;
        logic [8:0] pcnt;
        logic [16:0] addr;
    } frame_info_t;

endpackage : flash_pkg

/* File: rtl/spi_flash_engine.sv */
// Serial flash command engine: read, dual read, page program and page erase
`timescale 1ns/1ps
// How it works
// - Accept fast and slow single read opcodes
// - Read address counter advances automatically
// - Data shifted out MSB first after header
// - Read wraps from top to zero
// - Chip select high ends read, output floats
// - Dual read drives bit pairs, high first
// - Chip select high floats both pins
// - Program data captured into page buffer
// - No programming without write enable latch
// - Program data wraps within its page
// - Only last 256 bytes kept
// - Frame end programs buffered bytes self-timed
// - Incomplete or unaligned program frame aborts
// - Protected target: no program, back idle
// - Aborted program clears write enable latch
// - Busy while programming, latch cleared early
// - Failed program byte sets error flag
// - Frame end erases page, busy meanwhile
// - Failed erase byte sets error flag
// - Sample on rising, drive on falling edge
// - Unsupported opcode ignored until next frame
// - Address bits above sixteen ignored
module spi_flash_engine #(
    parameter int ADDR_W = flash_pkg::ARRAY_ADDR_W
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic second_data_pin_i,
    output logic so_o,
    output logic so_oe_n_o,
    output logic second_data_pin_o,
    output logic second_data_pin_oe_n_o,
    input wire logic write_enable_set_i,
    input wire logic protect_i,
    output logic write_enable_latch_o,
    output logic busy_o,
    output logic program_erase_error_flag_o
);

    // ==========================================================
    // Storage
    logic [7:0] mem [0:(1 << ADDR_W) - 1];
    logic [7:0] page_buf [0:255];

    // Array powers up erased; reset does not touch it
    initial begin
        for (int i = 0; i < (1 << ADDR_W); i++) begin
            mem[i] = flash_pkg::ERASED_BYTE;
        end
    end

    // ==========================================================
    // Link side, rising edge: header and program data capture
    logic cs_rst;
    logic active_q;
    logic [2:0] bitpos_q;
    logic [2:0] nbytes_q;
    logic [7:0] sr_q;
    flash_pkg::cmd_t cmd_q;
    logic [16:0] addr_q;
    logic [8:0] pcnt_q;
    logic rd_go_q;
    logic [2:0] dcnt_q;
    logic [ADDR_W-1:0] rd_addr_q;

    // Frame state restarts whenever chip select is high
    assign cs_rst = rst_i | cs_n_i;

    wire first = !active_q;
    wire [2:0] bitpos_cur = first ? 3'h0 : bitpos_q;
    wire [2:0] nb_cur = first ? 3'h0 : nbytes_q;
    wire byte_done = (bitpos_cur == 3'h7);
    wire [7:0] sr_d = {(first ? 7'h00 : sr_q[6:0]), second_data_pin_i};
    wire [16:0] addr_d = {addr_q[8:0], sr_d};

    wire flash_pkg::cmd_t cmd_dec =
        (sr_d == flash_pkg::OP_READ_SLOW) ? flash_pkg::CMD_READ :
        (sr_d == flash_pkg::OP_READ_FAST) ? flash_pkg::CMD_FAST :
        (sr_d == flash_pkg::OP_READ_DUAL) ? flash_pkg::CMD_DUAL :
        (sr_d == flash_pkg::OP_PROGRAM) ? flash_pkg::CMD_PROG :
        (sr_d == flash_pkg::OP_PAGE_ERASE) ? flash_pkg::CMD_ERASE :
        flash_pkg::CMD_NONE;

    wire is_read = (cmd_q == flash_pkg::CMD_READ) || (cmd_q == flash_pkg::CMD_FAST) ||
                   (cmd_q == flash_pkg::CMD_DUAL);
    wire is_dual = (cmd_q == flash_pkg::CMD_DUAL);
    // Fast and dual reads carry one dummy byte after the address
    wire [2:0] hdr_len = (cmd_q == flash_pkg::CMD_READ) ? flash_pkg::HDR_BYTES : flash_pkg::HDR_DUMMY_BYTES;
    wire rd_start = is_read && byte_done && (nb_cur == hdr_len - 3'h1) && !first;
    wire [ADDR_W-1:0] rd_base = (cmd_q == flash_pkg::CMD_READ) ? addr_d[ADDR_W-1:0] : addr_q[ADDR_W-1:0];
    wire [2:0] dcnt_last = is_dual ? flash_pkg::DUAL_LAST_PAIR : flash_pkg::SINGLE_LAST_BIT;

    wire prog_data = (cmd_q == flash_pkg::CMD_PROG) && byte_done && !first &&
                     (nb_cur >= flash_pkg::HDR_BYTES);

    // ==========================================================
    // Page buffer write index
    // Free-running within the page; pcnt_q saturates for the byte count
    logic [7:0] widx_q;
    wire [7:0] widx_d = first ? 8'h00 : (prog_data ? widx_q + 8'h01 : widx_q);

    always_ff @(posedge sck_i or posedge rst_i) begin
        if (rst_i) begin
            widx_q <= 8'h00;
        end else begin
            widx_q <= widx_d;
        end
    end

    wire [7:0] buf_idx = addr_q[7:0] + widx_q;
    wire [2:0] nbytes_d = (byte_done && nb_cur != flash_pkg::NBYTES_MAX) ? nb_cur + 3'h1 : nb_cur;

    always_ff @(posedge sck_i or posedge cs_rst) begin
        if (cs_rst) begin
            active_q <= 1'b0;
            rd_go_q <= 1'b0;
            dcnt_q <= 3'h0;
        end else begin
            active_q <= 1'b1;
            rd_go_q <= rd_go_q | rd_start;
            // Bit or pair counter: zero loads a new byte, then shifts
            if (rd_go_q) begin
                dcnt_q <= (dcnt_q == dcnt_last) ? 3'h0 : dcnt_q + 3'h1;
            end
        end
    end

    // Held after chip select rises so the system side can judge the frame
    always_ff @(posedge sck_i or posedge rst_i) begin
        if (rst_i) begin
            bitpos_q <= 3'h0;
            nbytes_q <= 3'h0;
            sr_q <= 8'h00;
            cmd_q <= flash_pkg::CMD_NONE;
            addr_q <= 17'h00000;
            pcnt_q <= 9'h000;
            rd_addr_q <= '0;
        end else begin
            bitpos_q <= bitpos_cur + 3'h1;
            nbytes_q <= nbytes_d;
            sr_q <= sr_d;
            if (first) begin
                pcnt_q <= 9'h000;
            end else if (prog_data && pcnt_q != flash_pkg::PAGE_BYTES) begin
                pcnt_q <= pcnt_q + 9'h001;
            end
            if (byte_done && nb_cur == 3'h0) begin
                cmd_q <= cmd_dec;
            end
            if (byte_done && nb_cur != 3'h0 && nb_cur < flash_pkg::HDR_BYTES) begin
                addr_q <= addr_d;
            end
            if (rd_start) begin
                rd_addr_q <= rd_base;
            end else if (rd_go_q && dcnt_q == 3'h0) begin
                rd_addr_q <= rd_addr_q + 1'b1;
            end
        end
    end

    // Overwrites wrap in the page, so the last 256 bytes survive
    always_ff @(posedge sck_i) begin
        if (prog_data) begin
            page_buf[buf_idx] <= sr_d;
        end
    end

    // ==========================================================
    // Link side, falling edge: read data out
    logic [7:0] sh_q;
    logic oe_q;

    always_ff @(negedge sck_i or posedge cs_rst) begin
        if (cs_rst) begin
            sh_q <= 8'h00;
            oe_q <= 1'b0;
        end else if (rd_go_q) begin
            oe_q <= 1'b1;
            if (dcnt_q == 3'h0) begin
                sh_q <= mem[rd_addr_q];
            end else if (is_dual) begin
                sh_q <= {sh_q[5:0], 2'b00};
            end else begin
                sh_q <= {sh_q[6:0], 1'b0};
            end
        end
    end

    // Enables follow chip select directly so the pins float at once
    assign so_o = sh_q[7];
    assign second_data_pin_o = sh_q[6];
    assign so_oe_n_o = !(oe_q && !cs_n_i);
    assign second_data_pin_oe_n_o = !(oe_q && is_dual && !cs_n_i);

    // ==========================================================
    // System side: frame end detection
    logic cs_meta_q;
    logic cs_sync_q;
    logic cs_prev_q;
    logic prot_meta_q;
    logic prot_q;

    // Two stages before anything reads chip select or protect
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cs_meta_q <= 1'b1;
            cs_sync_q <= 1'b1;
            cs_prev_q <= 1'b1;
            prot_meta_q <= 1'b0;
            prot_q <= 1'b0;
        end else begin
            cs_meta_q <= cs_n_i;
            cs_sync_q <= cs_meta_q;
            cs_prev_q <= cs_sync_q;
            prot_meta_q <= protect_i;
            prot_q <= prot_meta_q;
        end
    end

    wire frame_end = cs_sync_q && !cs_prev_q;

    // Link flops are quiet once chip select is high; two sync stages cover settling
    wire flash_pkg::frame_info_t info_now = '{cmd: cmd_q, nbytes: nbytes_q, bitpos: bitpos_q,
                                               pcnt: pcnt_q, addr: addr_q};

    // ==========================================================
    // System side: self-timed program and erase
    typedef enum logic [2:0] {
        S_IDLE,
        S_DECIDE,
        S_WRITE,
        S_WAIT,
        S_CHECK
    } state_t;

    state_t state_q;
    flash_pkg::frame_info_t snap_q;
    logic [8:0] idx_q;
    logic [11:0] tmr_q;
    logic wel_q;
    logic err_q;

    wire is_prog = (snap_q.cmd == flash_pkg::CMD_PROG);
    wire is_erase = (snap_q.cmd == flash_pkg::CMD_ERASE);
    wire aligned = (snap_q.bitpos == 3'h0);
    wire prog_ok = is_prog && aligned && (snap_q.nbytes == flash_pkg::NBYTES_MAX);
    wire erase_ok = is_erase && aligned && (snap_q.nbytes >= flash_pkg::HDR_BYTES);
    // Refused frames leave the latch alone; aborted ones clear it
    wire refused = !(is_prog || is_erase) || !wel_q;
    wire aborted = !refused && (!(prog_ok || erase_ok) || prot_q);
    wire starting = !refused && !aborted;

    wire [7:0] low_idx = is_prog ? snap_q.addr[7:0] + idx_q[7:0] : idx_q[7:0];
    wire [ADDR_W-1:0] wr_addr = {snap_q.addr[ADDR_W-1:flash_pkg::PAGE_ADDR_W], low_idx};
    wire [7:0] wr_data = is_prog ? page_buf[low_idx] : flash_pkg::ERASED_BYTE;
    wire [8:0] op_count = is_prog ? snap_q.pcnt : flash_pkg::PAGE_BYTES;
    wire [11:0] op_cyc = is_prog ? flash_pkg::BYTE_PROG_CYC : flash_pkg::BYTE_ERASE_CYC;
    wire last_byte = (idx_q + 9'h001 == op_count);
    wire byte_bad = (mem[wr_addr] != wr_data);
    wire wel_clr = (state_q == S_DECIDE) && !refused;

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= S_IDLE;
            snap_q <= '0;
            idx_q <= 9'h000;
            tmr_q <= 12'h000;
            err_q <= 1'b0;
        end else begin
            unique case (state_q)
                S_IDLE: begin
                    if (frame_end) begin
                        snap_q <= info_now;
                        state_q <= S_DECIDE;
                    end
                end
                S_DECIDE: begin
                    idx_q <= 9'h000;
                    if (starting) begin
                        err_q <= 1'b0;
                        state_q <= S_WRITE;
                    end else begin
                        state_q <= S_IDLE;
                    end
                end
                S_WRITE: begin
                    tmr_q <= 12'h000;
                    state_q <= S_WAIT;
                end
                S_WAIT: begin
                    tmr_q <= tmr_q + 12'h001;
                    if (tmr_q == op_cyc - 12'h001) begin
                        state_q <= S_CHECK;
                    end
                end
                S_CHECK: begin
                    if (byte_bad) begin
                        err_q <= 1'b1;
                    end
                    idx_q <= idx_q + 9'h001;
                    state_q <= last_byte ? S_IDLE : S_WRITE;
                end
                // Unused codes fall back to idle
                default: begin
                    state_q <= S_IDLE;
                end
            endcase
        end
    end

    // Programming only clears bits, so a target bit at zero where the data has a one fails the check
    always_ff @(posedge sys_clk_i) begin
        if (state_q == S_WRITE) begin
            mem[wr_addr] <= is_prog ? (mem[wr_addr] & wr_data) : wr_data;
        end
    end

    // Set pulse wins over a clear in the same cycle
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wel_q <= 1'b0;
        end else if (write_enable_set_i) begin
            wel_q <= 1'b1;
        end else if (wel_clr) begin
            wel_q <= 1'b0;
        end
    end

    assign write_enable_latch_o = wel_q;
    // Busy covers the decide cycle as well
    assign busy_o = (state_q != S_IDLE);
    assign program_erase_error_flag_o = err_q;

endmodule : spi_flash_engine

/* File: testbench/flash_engine_asserts.sv */
// Port checker for the flash command engine
`timescale 1ns/1ps
module flash_engine_asserts (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic so_o,
    input wire logic so_oe_n_o,
    input wire logic second_data_pin_o,
    input wire logic second_data_pin_oe_n_o,
    input wire logic write_enable_set_i,
    input wire logic protect_i,
    input wire logic write_enable_latch_o,
    input wire logic busy_o,
    input wire logic program_erase_error_flag_o
);
    logic [15:0] busy_cnt_q;
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) busy_cnt_q <= 16'h0;
        else busy_cnt_q <= busy_o ? busy_cnt_q + 16'h1 : 16'h0;
    end
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    // ==========================================
    // Pins
    AST_SO_FLOAT: assert property (cs_n_i |-> so_oe_n_o) else $error("so driven");
    AST_SIO_FLOAT: assert property (cs_n_i |-> second_data_pin_oe_n_o) else $error("sio driven");
    AST_SIO_LATE: assert property (!second_data_pin_oe_n_o |-> !so_oe_n_o) else $error("sio early");
    // Link is async: a rise since the last sample means no fall in between
    AST_EDGE: assert property ($rose(sck_i) |-> $stable(so_o)
        && (second_data_pin_oe_n_o || $stable(second_data_pin_o))) else $error("out on rise");
    // ==========================================
    // Write cycles
    AST_SET: assert property ($rose(write_enable_latch_o) |-> $past(write_enable_set_i)) else $error("latch set");
    AST_NO_LATCH: assert property (!write_enable_latch_o ##1 $rose(busy_o) |-> ##[1:4] !busy_o)
        else $error("ran unlatched");
    AST_PROT: assert property (protect_i [*6] ##1 $rose(busy_o) |-> ##[1:4] !busy_o) else $error("ran protected");
    AST_WEL_BUSY: assert property (busy_cnt_q > 16'h4 |-> !write_enable_latch_o) else $error("latch kept");
    AST_ERR_HOLD: assert property (!busy_o && !$past(busy_o) |-> $stable(program_erase_error_flag_o))
        else $error("error flag moved");
endmodule : flash_engine_asserts

/* File: testbench/spi_flash_read_program_erase_test.sv */
// Self-checking bench for the flash command engine
`timescale 1ns/1ps
module spi_flash_read_program_erase_test;
    logic sys_clk_i, rst_i, sck_i, cs_n_i, write_enable_set_i, protect_i, host_si;
    logic so_o, so_oe_n_o, second_data_pin_o, second_data_pin_oe_n_o;
    logic write_enable_latch_o, busy_o, program_erase_error_flag_o;
    logic [7:0] rx;
    int bad_count, checks, cyc;
    wire logic so_w = so_oe_n_o ? 1'bz : so_o;
    wire logic second_data_pin_i = second_data_pin_oe_n_o ? host_si : second_data_pin_o;
    wire logic [7:0] flags = {5'h0, write_enable_latch_o, busy_o, program_erase_error_flag_o};
    wire logic [7:0] oes = {6'h0, so_oe_n_o, second_data_pin_oe_n_o};
    spi_flash_engine dut (.sys_clk_i, .rst_i, .sck_i, .cs_n_i, .second_data_pin_i, .so_o, .so_oe_n_o,
        .second_data_pin_o, .second_data_pin_oe_n_o, .write_enable_set_i, .protect_i, .write_enable_latch_o,
        .busy_o, .program_erase_error_flag_o);
    spi_host_model host (.so_i(so_w), .sio_i(second_data_pin_i), .sck_o(sck_i), .cs_n_o(cs_n_i), .si_o(host_si));
    initial begin
        sys_clk_i = 1'b0;
        forever #4 sys_clk_i = ~sys_clk_i;
    end
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 99000) begin
            bad_count++;
            results();
        end
    end
    // ==========================================
    // Tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic results();
        $display("Comparisons %0d, mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : results
    task automatic wait_sys(input int n);
        repeat (n) @(negedge sys_clk_i);
    endtask : wait_sys
    task automatic set_latch();
        wait_sys(1);
        write_enable_set_i = 1'b1;
        wait_sys(1);
        write_enable_set_i = 1'b0;
    endtask : set_latch
    task automatic stop();
        host.sel(1'b0);
        wait_sys(10);
    endtask : stop
    task automatic idle();
        for (int k = 0; k < 40000 && busy_o !== 1'b0; k++) wait_sys(1);
    endtask : idle
    task automatic send(input logic [39:0] w, input int nb, input logic keep);
        host.sel(1'b1);
        for (int i = 0; i < 5; i++) begin
            if (nb > 8 * i) host.xfer(w[39 - 8 * i -: 8], (nb - 8 * i > 8) ? 8 : nb - 8 * i, 1'b0, rx);
        end
        if (!keep) stop();
    endtask : send
    task automatic prog(input logic [23:0] a, input int n, input logic [23:0] d);
        send({8'h02, a, d[23:16]}, 40, 1'b1);
        for (int j = 1; j < n; j++) host.xfer(d[23 - 8 * j -: 8], 8, 1'b0, rx);
        stop();
    endtask : prog
    // Second byte is cut off halfway on purpose
    task automatic rd(input logic [7:0] op, input logic [23:0] a, input logic [7:0] e0, input logic [7:0] e1);
        logic dual;
        dual = (op == 8'h3b);
        send({op, a, 8'h00}, (op == 8'h03) ? 32 : 40, 1'b1);
        host.xfer(8'h00, dual ? 4 : 8, dual, rx);
        chk(rx, e0);
        host.xfer(8'h00, dual ? 2 : 4, dual, rx);
        chk({4'h0, rx[3:0]}, {4'h0, e1[7:4]});
        stop();
        chk(oes, 8'h03);
    endtask : rd
    // ==========================================
    // Tests
    initial begin
        rst_i = 1'b1;
        write_enable_set_i = 1'b0;
        protect_i = 1'b0;
        wait_sys(3);
        rst_i = 1'b0;
        wait_sys(4);
        chk(flags, 8'h00);
        chk(oes, 8'h03);
        set_latch();
        prog(24'hff00fe, 3, 24'ha55ac3);
        chk(flags, 8'h02);
        idle();
        rd(8'h03, 24'h0100fd, 8'hff, 8'ha5);
        rd(8'h0b, 24'h0300ff, 8'h5a, 8'hff);
        rd(8'h03, 24'h010000, 8'hc3, 8'hff);
        $display("Test program finished");
        set_latch();
        prog(24'h01ffff, 3, 24'h96693c);
        idle();
        rd(8'h3b, 24'h01ffff, 8'h96, 8'hff);
        rd(8'h3b, 24'h01ff00, 8'h69, 8'h3c);
        $display("Test dual finished");
        set_latch();
        send(40'h8101ff0000, 32, 1'b0);
        chk(flags, 8'h02);
        idle();
        chk(flags, 8'h00);
        rd(8'h3b, 24'h01ffff, 8'hff, 8'hff);
        rd(8'h03, 24'h01ff00, 8'hff, 8'hff);
        $display("Test erase finished");
        prog(24'h000010, 1, 24'h120000);
        chk(flags, 8'h00);
        protect_i = 1'b1;
        set_latch();
        prog(24'h000010, 1, 24'h120000);
        chk(flags, 8'h00);
        protect_i = 1'b0;
        for (int nb = 20; nb <= 36; nb += 4) begin
            set_latch();
            send(40'h0200001012, nb, 1'b0);
            chk(flags, 8'h00);
        end
        rd(8'h03, 24'h000010, 8'hff, 8'hff);
        $display("Test refuse finished");
        set_latch();
        send(40'h8101000000, 16, 1'b0);
        chk(flags, 8'h00);
        rd(8'h03, 24'h0100fe, 8'ha5, 8'h5a);
        send(40'h9f030100fe, 40, 1'b1);
        host.xfer(8'h00, 8, 1'b0, rx);
        chk(oes, 8'h03);
        stop();
        $display("Test ignore finished");
        set_latch();
        prog(24'h0100fe, 1, 24'h5a0000);
        idle();
        chk(flags, 8'h01);
        set_latch();
        send(40'h8101000000, 32, 1'b0);
        idle();
        chk(flags, 8'h00);
        rd(8'h03, 24'h0100fe, 8'hff, 8'hff);
        $display("Test error finished");
        set_latch();
        send(40'h0200020000, 40, 1'b1);
        for (int k = 1; k <= 257; k++) host.xfer((k == 256) ? 8'h77 : (k == 257) ? 8'h88 : 8'(k), 8, 1'b0, rx);
        stop();
        idle();
        rd(8'h03, 24'h000200, 8'h77, 8'h88);
        $display("Test long finished");
        results();
    end
endmodule : spi_flash_read_program_erase_test
bind spi_flash_engine flash_engine_asserts chk_i (.sys_clk_i, .rst_i, .sck_i, .cs_n_i, .so_o, .so_oe_n_o,
    .second_data_pin_o, .second_data_pin_oe_n_o, .write_enable_set_i, .protect_i, .write_enable_latch_o,
    .busy_o, .program_erase_error_flag_o);

/* File: testbench/spi_host_model.sv */
// Serial host model: frames, clocks and exchanges bytes
`timescale 1ns/1ps
module spi_host_model (
    input wire logic so_i,
    input wire logic sio_i,
    output logic sck_o,
    output logic cs_n_o,
    output logic si_o
);
    localparam realtime HALF = 62.5;
    // Clock idles low between frames
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b0;
    end
    task automatic sel(input logic on);
        #HALF;
        cs_n_o = !on;
        #HALF;
    endtask : sel
    // Released pin toggles so a stale level never passes
    task automatic xfer(input logic [7:0] tx, input int n, input logic dual, output logic [7:0] rx);
        for (int i = 0; i < n; i++) begin
            si_o = dual ? ~si_o : tx[7 - i];
            #HALF;
            sck_o = 1'b1;
            rx = dual ? {rx[5:0], so_i, sio_i} : {rx[6:0], so_i};
            #HALF;
            sck_o = 1'b0;
        end
    endtask : xfer
endmodule : spi_host_model
